// ===== include/mxb_pkg.sv
package mxb_pkg;

    // ----------------------------------------
    // Control word layout
    // ----------------------------------------
    localparam int OP_HI = 3;
    localparam int OP_LO = 0;
    localparam int SEL_BIT = 3;
    localparam int F1_HI = 7;
    localparam int F1_LO = 4;
    localparam int F2_HI = 15;
    localparam int F2_LO = 8;

    // ----------------------------------------
    // Opcodes (bits 0..3 of the control word)
    // ----------------------------------------
    localparam logic [3:0] OPC_XOR_STORE = 4'he;
    localparam logic [3:0] OPC_XOR_NOSTORE = 4'hf;
    localparam logic [3:0] OPC_BRANCH_0 = 4'h2;
    localparam logic [3:0] OPC_BRANCH_1 = 4'h3;

    // ----------------------------------------
    // Condition selects (bit 0 + field one, as printed minus 20)
    // ----------------------------------------
    localparam logic [4:0] CS_ZERO = 5'h00;
    localparam logic [4:0] CS_NO_CARRY = 5'h01;
    localparam logic [4:0] CS_HW_ERROR = 5'h02;
    localparam logic [4:0] CS_FEATURE = 5'h03;
    localparam logic [4:0] CS_PARITY = 5'h04;
    localparam logic [4:0] CS_NO_END_A = 5'h05;
    localparam logic [4:0] CS_SELECT_OUT = 5'h06;
    localparam logic [4:0] CS_DATA_CHECK = 5'h07;
    localparam logic [4:0] CS_ADDR_OUT = 5'h08;
    localparam logic [4:0] CS_CMD_OUT = 5'h09;
    localparam logic [4:0] CS_SERVICE = 5'h0d;
    localparam logic [4:0] CS_DREG_BASE = 5'h10;
    localparam logic [4:0] CS_OPER_IN = 5'h18;
    localparam logic [4:0] CS_NO_END_B = 5'h1e;
    localparam logic [4:0] CS_OVERRUN = 5'h1f;

    // ----------------------------------------
    // Reset values and page forcing
    // ----------------------------------------
    localparam logic [7:0] IC_HIGH_RST = 8'h00;
    localparam logic [7:0] IC_LOW_RST = 8'h00;
    localparam logic [7:0] FEATURE_PAGE = 8'h04;

    typedef struct packed {
        logic [7:0] field2;
        logic [3:0] field1;
        logic [3:0] opcode;
    } mxb_word_t;

    // Channel tag inputs, both channels
    typedef struct packed {
        logic addr_out_a;
        logic addr_out_b;
        logic cmd_out_a;
        logic cmd_out_b;
        logic oper_in_a;
        logic oper_in_b;
        logic svc_in;
        logic svc_out;
    } mxb_tags_t;

endpackage

// ===== design/mxb_core.sv
`timescale 1ns/1ps
module mxb_core (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Control word, valid while i_exec is high
    input wire mxb_pkg::mxb_word_t i_word,
    input wire logic i_exec,
    // Data path
    input wire logic [7:0] i_a_load,
    input wire logic i_a_load_en,
    input wire logic [7:0] i_lsb_wdata,
    input wire logic [3:0] i_lsb_waddr,
    input wire logic i_lsb_we,
    // Pins from outside the clock domain
    input wire mxb_pkg::mxb_tags_t i_tags,
    input wire logic i_hw_error,
    input wire logic i_parity_error,
    input wire logic i_end_pending_a,
    input wire logic i_end_pending_b,
    input wire logic i_tape_op,
    input wire logic i_write_op,
    input wire logic i_data_check,
    input wire logic i_overrun,
    input wire logic i_clock_b_group,
    input wire logic i_data_end_writing,
    input wire logic i_select_out,
    input wire logic [31:0] i_other_cond,
    // Strap: two-channel or NRZI feature installed
    input wire logic i_feature_present,
    // Outputs
    output logic [7:0] o_a_reg,
    output logic [7:0] o_d_bus,
    output logic o_hilo_latch,
    output logic o_carry,
    output logic [7:0] o_instr_counter_high,
    output logic [7:0] o_instr_counter_low,
    output logic [7:0] o_control_store_addr,
    output logic o_branch_taken,
    output logic [7:0] o_lsb_rdata
);

    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    localparam int NS = 20;
    logic [NS-1:0] sync1;
    logic [NS-1:0] sync2;
    logic [NS-1:0] pins;
    assign pins = {i_tags, i_hw_error, i_parity_error, i_end_pending_a, i_end_pending_b,
                   i_tape_op, i_write_op, i_data_check, i_overrun, i_clock_b_group,
                   i_data_end_writing, i_select_out, i_feature_present};

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
        end
    end

    mxb_pkg::mxb_tags_t tags;
    logic s_hw_err, s_par, s_end_a, s_end_b, s_tape, s_write, s_dchk, s_ovr, s_clkb;
    logic s_dend, s_selo, s_feat;
    assign {tags, s_hw_err, s_par, s_end_a, s_end_b, s_tape, s_write, s_dchk, s_ovr,
            s_clkb, s_dend, s_selo, s_feat} = sync2;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic is_xor, is_xor_store, is_branch;
    logic [4:0] cond_sel;
    assign is_xor_store = i_exec && i_word.opcode == mxb_pkg::OPC_XOR_STORE;
    assign is_xor = i_exec && (i_word.opcode == mxb_pkg::OPC_XOR_STORE
                    || i_word.opcode == mxb_pkg::OPC_XOR_NOSTORE);
    assign is_branch = i_exec && (i_word.opcode == mxb_pkg::OPC_BRANCH_0
                       || i_word.opcode == mxb_pkg::OPC_BRANCH_1);
    // Opcode bit 0 is control word bit 0
    assign cond_sel = {i_word.opcode[0], i_word.field1};

    // ----------------------------------------
    // Local store and ALU
    // ----------------------------------------
    logic [7:0] lstore [16];
    logic [7:0] a_bus, b_bus, next_d;
    assign b_bus = lstore[i_word.field1];
    assign a_bus = o_a_reg | i_word.field2;
    assign next_d = a_bus ^ b_bus;

    // Store write: XOR store-back wins over the outside write port
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < 16; i++) begin
                lstore[i] <= 8'h00;
            end
        end else if (is_xor_store) begin
            lstore[i_word.field1] <= next_d;
        end else if (i_lsb_we) begin
            lstore[i_lsb_waddr] <= i_lsb_wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_lsb_rdata <= 8'h00;
        end else begin
            o_lsb_rdata <= lstore[i_lsb_waddr];
        end
    end

    // D bus holds until the next ALU operation
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_d_bus <= 8'h00;
            o_carry <= 1'b0;
        end else if (is_xor) begin
            o_d_bus <= next_d;
            o_carry <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_hilo_latch <= 1'b0;
        end else if (is_xor_store) begin
            o_hilo_latch <= i_word.field1[0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_a_reg <= 8'h00;
        end else if (is_xor) begin
            o_a_reg <= 8'h00;
        end else if (i_a_load_en && !is_branch) begin
            o_a_reg <= i_a_load;
        end
    end

    // ----------------------------------------
    // Condition select
    // ----------------------------------------
    logic cond_true;
    always_comb begin
        cond_true = i_other_cond[cond_sel];
        case (cond_sel)
            mxb_pkg::CS_ZERO: cond_true = o_d_bus == 8'h00;
            mxb_pkg::CS_NO_CARRY: cond_true = !o_carry;
            mxb_pkg::CS_HW_ERROR: cond_true = s_hw_err;
            mxb_pkg::CS_FEATURE: cond_true = s_feat;
            mxb_pkg::CS_PARITY: cond_true = s_par;
            mxb_pkg::CS_NO_END_A: cond_true = !s_end_a;
            mxb_pkg::CS_SELECT_OUT: cond_true = s_selo;
            mxb_pkg::CS_DATA_CHECK: cond_true = s_tape ? s_clkb : s_dchk;
            mxb_pkg::CS_ADDR_OUT: cond_true = tags.addr_out_a | tags.addr_out_b;
            mxb_pkg::CS_CMD_OUT: cond_true = tags.cmd_out_a | tags.cmd_out_b;
            mxb_pkg::CS_SERVICE: begin
                cond_true = s_write ? tags.svc_out : (tags.svc_in | tags.svc_out);
            end
            mxb_pkg::CS_OPER_IN: cond_true = tags.oper_in_a | tags.oper_in_b;
            mxb_pkg::CS_NO_END_B: cond_true = !s_end_b;
            mxb_pkg::CS_OVERRUN: cond_true = s_tape ? s_dend : s_ovr;
            default: begin
                if (cond_sel[4:3] == 2'b10) begin
                    cond_true = o_d_bus[cond_sel[2:0]];
                end
            end
        endcase
    end

    // ----------------------------------------
    // Instruction counter
    // ----------------------------------------
    logic taken;
    logic [15:0] ic_inc;
    assign taken = is_branch && cond_true;
    assign ic_inc = {o_instr_counter_high, o_instr_counter_low} + 16'h0001;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_instr_counter_high <= mxb_pkg::IC_HIGH_RST;
            o_instr_counter_low <= mxb_pkg::IC_LOW_RST;
        end else if (taken) begin
            o_instr_counter_low <= i_word.field2;
            if (cond_sel == mxb_pkg::CS_FEATURE) begin
                o_instr_counter_high <= mxb_pkg::FEATURE_PAGE;
            end
        end else if (i_exec) begin
            {o_instr_counter_high, o_instr_counter_low} <= ic_inc;
        end
    end

    // Target bypasses the counter so the next fetch needs no extra cycle
    assign o_branch_taken = taken;
    assign o_control_store_addr = taken ? i_word.field2 : o_instr_counter_low;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence xor_issue;
        is_xor;
    endsequence

    sequence xor_nostore_issue;
        is_xor && !is_xor_store;
    endsequence

    sequence branch_issue;
        is_branch;
    endsequence

    sequence taken_issue;
        branch_issue ##0 cond_true;
    endsequence

    sequence untaken_issue;
        branch_issue ##0 !cond_true;
    endsequence

    sequence feature_issue;
        branch_issue ##0 (cond_sel == mxb_pkg::CS_FEATURE && s_feat);
    endsequence

    sequence other_issue;
        i_exec && !is_xor && !is_branch;
    endsequence

    AST_XOR_CLEARS_A: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        xor_issue |=> o_a_reg == 8'h00) else $error("A register not cleared");
    AST_D_RESULT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        is_xor |=> o_d_bus == $past(next_d)) else $error("D bus wrong");
    AST_STORE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        is_xor_store |=> lstore[$past(i_word.field1)] == o_d_bus) else $error("no store");
    AST_NOSTORE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (xor_nostore_issue ##0 !i_lsb_we) |=> lstore[$past(i_word.field1)]
        == $past(lstore[i_word.field1])) else $error("store changed");
    AST_D_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        !is_xor |=> $stable(o_d_bus)) else $error("D bus not held");
    AST_BR_A: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        is_branch |=> $stable(o_a_reg)) else $error("branch changed A");
    AST_TAKEN_LOW: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        taken |=> o_instr_counter_low == $past(i_word.field2)) else $error("low not loaded");
    AST_ADDR: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        taken |-> o_control_store_addr == i_word.field2) else $error("address not routed");
    AST_FEATURE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (is_branch && cond_sel == mxb_pkg::CS_FEATURE && s_feat)
        |=> o_instr_counter_high == mxb_pkg::FEATURE_PAGE) else $error("page not forced");
    AST_NOT_TAKEN: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (is_branch && !cond_true) |=> {o_instr_counter_high, o_instr_counter_low}
        == $past(ic_inc)) else $error("no increment");
    AST_ZERO: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (branch_issue ##0 cond_sel == mxb_pkg::CS_ZERO) |=> o_instr_counter_low
        == ($past(o_d_bus) == 8'h00 ? $past(i_word.field2) : $past(ic_inc[7:0])))
        else $error("zero test wrong");
    AST_DBIT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (branch_issue ##0 cond_sel[4:3] == 2'b10) |=> o_instr_counter_low
        == ($past(o_d_bus[cond_sel[2:0]]) ? $past(i_word.field2) : $past(ic_inc[7:0])))
        else $error("D bit test wrong");

    // ----------------------------------------
    // Decode and data path checks
    // ----------------------------------------
    AST_STORE_DECODE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (i_exec && i_word.opcode == mxb_pkg::OPC_XOR_STORE) |=> o_hilo_latch
        == $past(i_word.field1[0])) else $error("store variant not decoded");

    AST_PLAIN_DECODE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (i_exec && i_word.opcode == mxb_pkg::OPC_XOR_NOSTORE) |=> $stable(o_hilo_latch)
        && o_a_reg == 8'h00) else $error("plain variant not decoded");

    AST_B_BUS: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        xor_issue |=> o_d_bus == ($past(lstore[i_word.field1]) ^ $past(a_bus)))
        else $error("B bus not from store");

    AST_A_BUS: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        xor_issue |=> o_d_bus == ($past(o_a_reg | i_word.field2) ^ $past(b_bus)))
        else $error("A bus not OR of constant");

    AST_NO_CARRY: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        xor_issue |=> !o_carry) else $error("carry after XOR");

    AST_REFUSED: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (other_issue ##0 !i_a_load_en) |=> $stable(o_d_bus) && $stable(o_a_reg)
        && o_instr_counter_low == $past(ic_inc[7:0])) else $error("other opcode acted");

    // ----------------------------------------
    // Branch condition checks
    // ----------------------------------------
    AST_BR_DECODE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (i_exec && i_word.opcode[3:1] == 3'h1) |-> o_branch_taken == cond_true)
        else $error("branch not decoded");

    AST_SELECT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (branch_issue ##0 cond_sel[4:1] == 4'h5) |-> o_branch_taken
        == i_other_cond[cond_sel]) else $error("plain select wrong");

    AST_HW_ERROR: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (branch_issue ##0 cond_sel == mxb_pkg::CS_HW_ERROR) |-> o_branch_taken
        == s_hw_err) else $error("error test wrong");

    AST_PARITY: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (branch_issue ##0 cond_sel == mxb_pkg::CS_PARITY) |-> o_branch_taken
        == s_par) else $error("parity test wrong");

    AST_ADDR_TAG: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (branch_issue ##0 cond_sel == mxb_pkg::CS_ADDR_OUT) |-> o_branch_taken
        == (tags.addr_out_a || tags.addr_out_b)) else $error("address tag wrong");

    AST_CMD_TAG: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (branch_issue ##0 cond_sel == mxb_pkg::CS_CMD_OUT) |-> o_branch_taken
        == (tags.cmd_out_a || tags.cmd_out_b)) else $error("command tag wrong");

    AST_OPER_TAG: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (branch_issue ##0 cond_sel == mxb_pkg::CS_OPER_IN) |-> o_branch_taken
        == (tags.oper_in_a || tags.oper_in_b)) else $error("operation tag wrong");

    AST_SVC_WRITE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (branch_issue ##0 cond_sel == mxb_pkg::CS_SERVICE && s_write) |-> o_branch_taken
        == tags.svc_out) else $error("write service test wrong");

    AST_SVC_READ: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (branch_issue ##0 cond_sel == mxb_pkg::CS_SERVICE && !s_write) |-> o_branch_taken
        == (tags.svc_in || tags.svc_out)) else $error("read service test wrong");

    AST_END_A: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (branch_issue ##0 cond_sel == mxb_pkg::CS_NO_END_A) |-> o_branch_taken
        == !s_end_a) else $error("end pending A wrong");

    AST_END_B: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (branch_issue ##0 cond_sel == mxb_pkg::CS_NO_END_B) |-> o_branch_taken
        == !s_end_b) else $error("end pending B wrong");

    AST_DCHK: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (branch_issue ##0 cond_sel == mxb_pkg::CS_DATA_CHECK) |-> o_branch_taken
        == (s_tape ? s_clkb : s_dchk)) else $error("data check test wrong");

    AST_OVERRUN: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (branch_issue ##0 cond_sel == mxb_pkg::CS_OVERRUN) |-> o_branch_taken
        == (s_tape ? s_dend : s_ovr)) else $error("overrun test wrong");

    AST_FEAT_TAKEN: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        feature_issue |-> o_branch_taken) else $error("feature branch not taken");

    AST_TAKEN_HIGH: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (taken_issue ##0 cond_sel != mxb_pkg::CS_FEATURE) |=> $stable(o_instr_counter_high))
        else $error("high counter moved");

    AST_UNTAKEN_ADDR: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        untaken_issue |-> o_control_store_addr == o_instr_counter_low)
        else $error("address not sequential");

endmodule

// ===== verif/mxb_chan_model.sv
`timescale 1ns/1ps
module mxb_chan_model (
    // Clock
    input wire logic i_sys_clk,
    // Levels requested by the bench, one bit each
    input wire logic [19:0] i_set,
    // Channel and status levels toward the block
    output mxb_pkg::mxb_tags_t o_tags,
    output logic o_feature_present,
    output logic o_select_out,
    output logic o_data_end_writing,
    output logic o_clock_b_group,
    output logic o_overrun,
    output logic o_data_check,
    output logic o_write_op,
    output logic o_tape_op,
    output logic o_end_pending_b,
    output logic o_end_pending_a,
    output logic o_parity_error,
    output logic o_hw_error
);
    // ----------------------------------------
    // Channel side levels
    // ----------------------------------------
    // Moved just after an edge so the block's synchronisers see clean levels
    always_ff @(posedge i_sys_clk) begin
        {o_tags, o_feature_present, o_select_out, o_data_end_writing, o_clock_b_group,
         o_overrun, o_data_check, o_write_op, o_tape_op, o_end_pending_b,
         o_end_pending_a, o_parity_error, o_hw_error} <= i_set;
    end
endmodule

// ===== verif/microprogram_xor_and_branch_tb.sv
`timescale 1ns/1ps
module microprogram_xor_and_branch_tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    mxb_pkg::mxb_word_t i_word = '0;
    logic i_exec = 1'b0;
    logic [7:0] i_a_load = 8'h00;
    logic i_a_load_en = 1'b0;
    logic [7:0] i_lsb_wdata = 8'h00;
    logic [3:0] i_lsb_waddr = 4'h0;
    logic i_lsb_we = 1'b0;
    logic [19:0] cond_set = 20'h00000;
    logic [31:0] i_other_cond = 32'h00000400;
    mxb_pkg::mxb_tags_t tags;
    logic feat, selo, dend, clkb, ovr, dchk, wop, top, endb, enda, par, hwe;
    logic [7:0] o_a_reg, o_d_bus, o_ich, o_icl, o_csa, o_lsb_rdata;
    logic o_hilo_latch, o_branch_taken, o_carry;
    logic [7:0] exp_low = 8'h00;
    logic [7:0] d_exp = 8'ha2;
    int mismatches = 0;
    int n_compared = 0;
    // Pins, select, taken
    logic [25:0] rows [21] = '{
        {20'h00001, 5'h02, 1'b1}, {20'h00000, 5'h02, 1'b0}, {20'h00002, 5'h04, 1'b1},
        {20'h00004, 5'h05, 1'b0}, {20'h00000, 5'h05, 1'b1}, {20'h00008, 5'h1e, 1'b0},
        {20'h40000, 5'h08, 1'b1}, {20'h20000, 5'h09, 1'b1}, {20'h04000, 5'h18, 1'b1},
        {20'h80000, 5'h18, 1'b0}, {20'h02020, 5'h0d, 1'b0}, {20'h02000, 5'h0d, 1'b1},
        {20'h01020, 5'h0d, 1'b1}, {20'h00040, 5'h07, 1'b1}, {20'h00050, 5'h07, 1'b0},
        {20'h00110, 5'h07, 1'b1}, {20'h00080, 5'h1f, 1'b1}, {20'h00210, 5'h1f, 1'b1},
        {20'h00090, 5'h1f, 1'b0}, {20'h00000, 5'h0a, 1'b1}, {20'h00000, 5'h0b, 1'b0}
    };

    initial begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    mxb_chan_model mxb_chan_model_i (.i_sys_clk(i_sys_clk), .i_set(cond_set), .o_tags(tags),
        .o_feature_present(feat), .o_select_out(selo), .o_data_end_writing(dend),
        .o_clock_b_group(clkb), .o_overrun(ovr), .o_data_check(dchk), .o_write_op(wop),
        .o_tape_op(top), .o_end_pending_b(endb), .o_end_pending_a(enda),
        .o_parity_error(par), .o_hw_error(hwe));

    mxb_core mxb_core_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_word(i_word),
        .i_exec(i_exec), .i_a_load(i_a_load), .i_a_load_en(i_a_load_en),
        .i_lsb_wdata(i_lsb_wdata), .i_lsb_waddr(i_lsb_waddr), .i_lsb_we(i_lsb_we),
        .i_tags(tags), .i_hw_error(hwe), .i_parity_error(par), .i_end_pending_a(enda),
        .i_end_pending_b(endb), .i_tape_op(top), .i_write_op(wop), .i_data_check(dchk),
        .i_overrun(ovr), .i_clock_b_group(clkb), .i_data_end_writing(dend),
        .i_select_out(selo), .i_other_cond(i_other_cond), .i_feature_present(feat),
        .o_a_reg(o_a_reg), .o_d_bus(o_d_bus), .o_hilo_latch(o_hilo_latch), .o_carry(o_carry),
        .o_instr_counter_high(o_ich), .o_instr_counter_low(o_icl),
        .o_control_store_addr(o_csa), .o_branch_taken(o_branch_taken),
        .o_lsb_rdata(o_lsb_rdata));

    // ----------------------------------------
    // Compare and bus tasks
    // ----------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask

    function automatic mxb_pkg::mxb_word_t brw(input logic [4:0] sel, input logic [7:0] tgt);
        return {tgt, sel[3:0], 3'b001, sel[4]};
    endfunction

    task automatic load_a(input logic [7:0] v);
        @(posedge i_sys_clk);
        i_a_load <= v;
        i_a_load_en <= 1'b1;
        @(posedge i_sys_clk);
        i_a_load_en <= 1'b0;
    endtask

    // Address and taken are combinational, so they are looked at in the exec cycle
    task automatic run(input mxb_pkg::mxb_word_t w, input logic tk);
        @(posedge i_sys_clk);
        i_exec <= 1'b1;
        i_word <= w;
        #1;
        if (w.opcode[3:1] == 3'h1) begin
            chk1(o_branch_taken, tk);
            chk8(o_csa, tk ? w.field2 : exp_low);
        end
        exp_low = (w.opcode[3:1] == 3'h1 && tk) ? w.field2 : exp_low + 8'h01;
        @(posedge i_sys_clk);
        i_exec <= 1'b0;
        #1;
        chk8(o_icl, exp_low);
    endtask

    task automatic tally_and_finish;
        $display("Compared %0d, mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Whole run is well under 2000 cycles
    initial begin
        #50000;
        mismatches++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        #1;
        chk8(o_d_bus, 8'h00);
        chk8(o_ich, mxb_pkg::IC_HIGH_RST);
        chk8(o_icl, mxb_pkg::IC_LOW_RST);
        @(posedge i_sys_clk);
        i_lsb_we <= 1'b1;
        i_lsb_waddr <= 4'h3;
        i_lsb_wdata <= 8'h3c;
        @(posedge i_sys_clk);
        i_lsb_we <= 1'b0;
        load_a(8'h5a);
        for (int k = 0; k < 21; k++) begin
            @(posedge i_sys_clk);
            cond_set <= rows[k][25:6];
            repeat (4) @(posedge i_sys_clk);
            run(brw(rows[k][5:1], 8'h40 + 8'(k)), rows[k][0]);
            chk8(o_a_reg, 8'h5a);
        end
        // Storing variant: (81|0f)^3c
        load_a(8'h81);
        run({8'h0f, 4'h3, mxb_pkg::OPC_XOR_STORE}, 1'b0);
        chk8(o_d_bus, 8'hb3);
        chk8(o_a_reg, 8'h00);
        chk1(o_hilo_latch, 1'b1);
        chk1(o_carry, 1'b0);
        @(posedge i_sys_clk);
        #1;
        chk8(o_lsb_rdata, 8'hb3);
        // Non-storing variant: (10|01)^b3, store must keep b3
        load_a(8'h10);
        run({8'h01, 4'h3, mxb_pkg::OPC_XOR_NOSTORE}, 1'b0);
        chk8(o_d_bus, 8'ha2);
        chk8(o_a_reg, 8'h00);
        @(posedge i_sys_clk);
        #1;
        chk8(o_lsb_rdata, 8'hb3);
        for (int i = 0; i < 8; i++) begin
            run(brw(5'h10 + 5'(i), 8'h20 + 8'(i)), d_exp[i]);
        end
        chk8(o_d_bus, 8'ha2);
        // Zero result from an untouched store byte
        run({8'h00, 4'h5, mxb_pkg::OPC_XOR_NOSTORE}, 1'b0);
        chk8(o_d_bus, 8'h00);
        run(brw(mxb_pkg::CS_ZERO, 8'h61), 1'b1);
        run(brw(mxb_pkg::CS_NO_CARRY, 8'h62), 1'b1);
        // Opcodes outside the block only step the counter
        run({8'hff, 4'hf, 4'h8}, 1'b0);
        chk8(o_d_bus, 8'h00);
        chk8(o_a_reg, 8'h00);
        @(posedge i_sys_clk);
        cond_set <= 20'h00800;
        repeat (4) @(posedge i_sys_clk);
        run(brw(mxb_pkg::CS_FEATURE, 8'h77), 1'b1);
        chk8(o_ich, mxb_pkg::FEATURE_PAGE);
        // Mid-run reset, then the strap branch again from a cleared counter
        @(posedge i_sys_clk);
        i_rstn <= 1'b0;
        @(posedge i_sys_clk);
        #1;
        chk8(o_ich, mxb_pkg::IC_HIGH_RST);
        chk8(o_icl, mxb_pkg::IC_LOW_RST);
        chk8(o_lsb_rdata, 8'h00);
        @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        exp_low = mxb_pkg::IC_LOW_RST;
        repeat (3) @(posedge i_sys_clk);
        run(brw(mxb_pkg::CS_FEATURE, 8'h55), 1'b1);
        chk8(o_ich, mxb_pkg::FEATURE_PAGE);
        tally_and_finish();
    end
endmodule
